//--- bench/gsp_link_bench.sv
/*
 Bench joining host and device ends through the link interface; drives the
 host over AXI4-Lite and checks the bytes the device sees and returns.
 Assumes the package constants and the hand-over timing of both ends.
*/
module gsp_link_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import gsp_pkg::*;
   logic aclk = 1'b0;
   logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic usr_we, wr_strobe, three_wire, two_wire_sel;
   logic [5:0] usr_addr, wr_addr, wr_seen_a;
   logic [7:0] usr_wdata, wr_data, wr_seen_d;
   int n_fail = 0;
   int n_tests = 0;
   int n_wr = 0;

   gsp_link_if u_gsp_link_if ();
   gsp_host u_gsp_host (.aclk, .aresetn, .link(u_gsp_link_if), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   gsp_dev u_gsp_dev (.aclk, .aresetn, .link(u_gsp_link_if), .usr_we, .usr_addr, .usr_wdata, .wr_strobe,
      .wr_addr, .wr_data, .three_wire, .two_wire_sel);
   gsp_link_sva u_gsp_link_sva (.aclk, .aresetn, .cs_n(u_gsp_link_if.cs_n), .sclk(u_gsp_link_if.sclk),
      .host_sdi_o(u_gsp_link_if.host_sdi_o), .host_sdi_oe(u_gsp_link_if.host_sdi_oe),
      .dev_sdi_oe(u_gsp_link_if.dev_sdi_oe), .dev_sdo_oe(u_gsp_link_if.dev_sdo_oe),
      .sdi_line(u_gsp_link_if.sdi_line));

   // Free-running system clock
   always #(GSP_CLK_NS / 2.0) aclk = ~aclk;

   // Record every byte the master writes into the device
   always @(posedge aclk)
   begin
      if (wr_strobe === 1'b1)
      begin
         n_wr <= n_wr + 1;
         wr_seen_a <= wr_addr;
         wr_seen_d <= wr_data;
      end
   end

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // A wait that runs out ends the run as a failure
   task automatic hang;
      chk("wait limit", 32'h0, 32'h1);
      complete_run();
   endtask : hang

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 64; i++)
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      if (i == 64) hang();
      chk("bresp", s_axi_bresp, GSP_RESP_OKAY);
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 64; i++)
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      if (i == 64) hang();
      chk("rresp", s_axi_rresp, GSP_RESP_OKAY);
   endtask : axi_rd

   task automatic start(input logic rw, inc, tw, input logic [1:0] len, input logic [5:0] ad, input logic [31:0] tx);
      axi_wr(GSP_OFS_TXD, tx);
      axi_wr(GSP_OFS_CTRL, {18'h0, ad, 2'b00, len, tw, inc, rw, 1'b1});
   endtask : start

   // Poll until the frame is over, clear done, then fetch received data
   task automatic finish;
      int i;
      for (i = 0; i < 300; i++)
      begin
         axi_rd(GSP_OFS_STAT, rv);
         if (rv[GSP_STAT_DONE] === 1'b1) break;
      end
      if (i == 300) hang();
      axi_wr(GSP_OFS_STAT, 32'h0000_0002);
      axi_rd(GSP_OFS_RXD, rv);
   endtask : finish

   task automatic frame(input logic rw, inc, tw, input logic [1:0] len, input logic [5:0] ad, input logic [31:0] tx);
      start(rw, inc, tw, len, ad, tx);
      finish();
   endtask : frame

   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, usr_we} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, usr_addr, usr_wdata} = 54'h0;
      s_axi_wstrb = 4'hf;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(GSP_OFS_CTRL, rv);
      chk("ctrl reset", rv, 32'h0);
      axi_rd(GSP_OFS_STAT, rv);
      chk("stat reset", rv, 32'h0);
      chk("two wire when idle", two_wire_sel, 1'b1);
      chk("mode reset", three_wire, 1'b0);
      $display("test reset done");
      frame(1'b0, 1'b0, 1'b0, 2'd0, 6'h10, 32'h0000_00a5);
      chk("single write count", n_wr, 32'd1);
      chk("single write addr", wr_seen_a, 6'h10);
      chk("single write data", wr_seen_d, 8'ha5);
      frame(1'b0, 1'b1, 1'b0, 2'd3, 6'h3e, 32'h4433_2211);
      chk("burst write count", n_wr, 32'd5);
      chk("burst last addr", wr_seen_a, 6'h01);
      chk("burst last data", wr_seen_d, 8'h44);
      $display("test writes done");
      frame(1'b1, 1'b0, 1'b0, 2'd1, 6'h3f, 32'h0);
      chk("fixed addr read", rv[15:0], 16'h2222);
      frame(1'b1, 1'b1, 1'b0, 2'd3, 6'h3e, 32'h0);
      chk("stepped read", rv, 32'h4433_2211);
      frame(1'b1, 1'b0, 1'b0, 2'd0, 6'h10, 32'h0);
      chk("single read", rv[7:0], 8'ha5);
      chk("reads store nothing", n_wr, 32'd5);
      $display("test reads done");
      start(1'b0, 1'b0, 1'b0, 2'd0, 6'h20, 32'h0000_005a);
      axi_wr(GSP_OFS_TXD, 32'h0000_0099);
      axi_rd(GSP_OFS_STAT, rv);
      chk("busy during frame", rv[GSP_STAT_BUSY], 1'b1);
      chk("port selected", two_wire_sel, 1'b0);
      finish();
      axi_rd(GSP_OFS_TXD, rv);
      chk("txd kept while busy", rv[7:0], 8'h5a);
      chk("frame data", wr_seen_d, 8'h5a);
      $display("test busy done");
      @(posedge aclk);
      usr_we <= 1'b1;
      usr_addr <= GSP_CTRL2_ADDR;
      usr_wdata <= 8'h01;
      @(posedge aclk);
      usr_we <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("three wire on", three_wire, 1'b1);
      frame(1'b1, 1'b0, 1'b1, 2'd0, 6'h3f, 32'h0);
      chk("three wire read", rv[7:0], 8'h22);
      frame(1'b1, 1'b1, 1'b1, 2'd1, 6'h3e, 32'h0);
      chk("three wire burst", rv[15:0], 16'h2211);
      frame(1'b0, 1'b0, 1'b1, 2'd0, GSP_CTRL2_ADDR, 32'h0);
      chk("three wire off", three_wire, 1'b0);
      frame(1'b1, 1'b0, 1'b0, 2'd0, 6'h3f, 32'h0);
      chk("four wire again", rv[7:0], 8'h22);
      $display("test three wire done");
      complete_run();
   end
endmodule : gsp_link_bench

//--- bench/gsp_link_sva.sv
/*
 Checker for the serial link between host and device ends.
 Assumes it sees the interface signals and the host's aclk domain directly.
*/
module gsp_link_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic host_sdi_o,
   input wire logic host_sdi_oe,
   input wire logic dev_sdi_oe,
   input wire logic dev_sdo_oe,
   input wire logic sdi_line
);
   logic sclk_q;
   logic [5:0] rise_cnt_q;
   logic rw_q;

   // Count clock rises inside a frame; cleared while deselected
   always_ff @(posedge aclk)
   begin
      sclk_q <= sclk;
      if (!aresetn || cs_n)
      begin
         rise_cnt_q <= 6'h00;
      end
      else if (sclk && !sclk_q)
      begin
         rise_cnt_q <= rise_cnt_q + 6'h01;
      end
   end

   // Direction bit, taken at the first rise of the frame
   always_ff @(posedge aclk)
   begin
      if (!aresetn || cs_n)
      begin
         rw_q <= 1'b0;
      end
      else if (sclk && !sclk_q && rise_cnt_q == 6'h00)
      begin
         rw_q <= sdi_line;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_sclk_idle: assert property (cs_n |-> sclk)
      else $error("link clock low while deselected");
   a_lead_high: assert property ($fell(cs_n) |-> sclk [*4])
      else $error("link clock fell too soon after select");
   a_half_period: assert property ($fell(sclk) |-> (!sclk) [*4] ##1 sclk)
      else $error("link clock low phase not four cycles");
   a_frame_len: assert property ($rose(cs_n) |-> rise_cnt_q inside {6'd16, 6'd24, 6'd32, 6'd40})
      else $error("frame length not sixteen plus whole bytes");
   a_host_stable: assert property ($rose(sclk) |-> $stable(host_sdi_o))
      else $error("host data moved at sampling edge");
   a_read_drive: assert property ($fell(sclk) && rise_cnt_q == 6'd8 && rw_q |-> ##[1:4] (dev_sdo_oe || dev_sdi_oe))
      else $error("device did not drive read data at byte start");
   a_early_quiet: assert property (!cs_n && rise_cnt_q < 6'd8 |-> !dev_sdo_oe && !dev_sdi_oe)
      else $error("device drove during command bits");
   a_write_quiet: assert property (!rw_q && rise_cnt_q != 6'd0 |-> !dev_sdo_oe && !dev_sdi_oe)
      else $error("device drove during write frame");
   a_idle_quiet: assert property (cs_n [*6] |-> !dev_sdo_oe && !dev_sdi_oe)
      else $error("device output kept while deselected");
   a_one_driver: assert property (dev_sdi_oe |-> !dev_sdo_oe && !host_sdi_oe)
      else $error("shared line has two drivers");
endmodule : gsp_link_sva

//--- core/gsp_dev.sv
/*
 Device end of the serial register port: a 64 x 8 register file reached by an
 external master over the serial link, plus a local write port.
 Assumes the master keeps chip select and clock idle high and runs the link
 clock at no more than a quarter of aclk.
*/
// Function
// [RL1] Master frames transfers with chip select low
// [RL2] Master idles serial clock high between frames
// [RL3] Drive on falling edge, sample on rising
// [RL4] Sixteen pulses, plus eight per extra byte
// [RL5] First fall starts bit zero
// [RL6] First bit chooses write or read
// [RL7] Read data driven from bit eight
// [RL8] Second bit enables address stepping
// [RL9] Six address bits, MSB first
// [RL10] One data byte, MSB first
// [RL11] Further bytes follow while selected
// [RL12] Control bit selects three-wire mode
// [RL13] Three-wire supports single and multi reads
// [RL14] Three-wire read data on input line
// [RL15] Chip select high selects two-wire mode
// [RL16] Output released when idle or writing
module gsp_dev #(
   parameter int NREGS = gsp_pkg::GSP_NREGS
) (
   input wire logic aclk,
   input wire logic aresetn,
   gsp_link_if.dev link,
   input wire logic usr_we,
   input wire logic [gsp_pkg::GSP_ADDR_W-1:0] usr_addr,
   input wire logic [7:0] usr_wdata,
   output logic wr_strobe,
   output logic [gsp_pkg::GSP_ADDR_W-1:0] wr_addr,
   output logic [7:0] wr_data,
   output logic three_wire,
   output logic two_wire_sel
);
   import gsp_pkg::*;

   localparam logic [3:0] CMD_LAST = 4'(GSP_CMD_BITS - 1);
   localparam logic [3:0] FIRST_DATA = 4'(GSP_CMD_BITS);
   localparam logic [3:0] FRAME_LAST = 4'(GSP_FRAME_BITS - 1);

   logic [GSP_SYNC_STAGES:0] cs_s_q;
   logic [GSP_SYNC_STAGES:0] sck_s_q;
   logic [GSP_SYNC_STAGES-1:0] sdi_s_q;
   logic active;
   logic rise;
   logic fall;
   logic [3:0] bit_q;
   logic [6:0] rx_q;
   logic [7:0] rx_byte;
   logic rw_q;
   logic inc_q;
   logic [GSP_ADDR_W-1:0] addr_q;
   logic [7:0] tx_q;
   logic drive_q;
   logic byte_done;
   logic [7:0] mem [NREGS];

   // Pins come from the master's domain; stage 0 feeds stage 1 only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cs_s_q <= '1;
         sck_s_q <= '1;
         sdi_s_q <= '1;
      end
      else
      begin
         cs_s_q <= {cs_s_q[GSP_SYNC_STAGES-1:0], link.cs_n};
         sck_s_q <= {sck_s_q[GSP_SYNC_STAGES-1:0], link.sclk};
         sdi_s_q <= {sdi_s_q[0], link.sdi_line};
      end
   end

   // Edges are only meaningful inside a frame, so a stray clock glitch while idle is ignored
   assign active = !cs_s_q[1]; // [RL1]
   assign rise = active && sck_s_q[1] && !sck_s_q[2]; // [RL3]
   assign fall = active && !sck_s_q[1] && sck_s_q[2]; // [RL3]
   assign rx_byte = {rx_q, sdi_s_q[1]};
   assign byte_done = rise && (bit_q == FRAME_LAST);

   // Bit position counts rising edges; the clock idles high, so the first fall opens bit 0
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         bit_q <= '0;
      else if (!active)
         bit_q <= '0; // [RL5]
      else if (rise)
         bit_q <= (bit_q == FRAME_LAST) ? FIRST_DATA : bit_q + 4'h1; // [RL4] [RL11]
   end

   // Serial input shifter, MSB first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_q <= '0;
      else if (rise)
         rx_q <= rx_byte[6:0]; // [RL3]
   end

   // Command byte decode, then address stepping after each data byte
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rw_q <= 1'b0;
         inc_q <= 1'b0;
         addr_q <= '0;
      end
      else if (rise && bit_q == CMD_LAST)
      begin
         rw_q <= rx_byte[GSP_RW_POS]; // [RL6]
         inc_q <= rx_byte[GSP_INC_POS]; // [RL8]
         addr_q <= rx_byte[GSP_ADDR_W-1:0]; // [RL9]
      end
      else if (byte_done && inc_q)
         addr_q <= addr_q + 6'h01; // [RL8]
   end

   // Register file; a link write wins over a local write in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < NREGS; i++)
            mem[i] <= GSP_REG_RST;
      end
      else if (byte_done && !rw_q)
         mem[addr_q] <= rx_byte; // [RL10] [RL11]
      else if (usr_we)
         mem[usr_addr] <= usr_wdata;
   end

   // Report each byte the master wrote
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_strobe <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
      end
      else
      begin
         wr_strobe <= byte_done && !rw_q;
         if (byte_done && !rw_q)
         begin
            wr_addr <= addr_q;
            wr_data <= rx_byte;
         end
      end
   end

   // Output shifter: load at the fall opening each data byte, else shift
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tx_q <= '0;
      else if (fall && bit_q == FIRST_DATA)
         tx_q <= mem[addr_q]; // [RL7] [RL11]
      else if (fall)
         tx_q <= {tx_q[6:0], 1'b0}; // [RL3]
   end

   // Drive only during the data part of a read frame
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         drive_q <= 1'b0;
      else if (!active)
         drive_q <= 1'b0; // [RL16]
      else if (fall && bit_q == FIRST_DATA && rw_q)
         drive_q <= 1'b1; // [RL7] [RL13]
   end

   // Pin-level protocol select, held in a flop so the output is clean
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         two_wire_sel <= 1'b1;
      else
         two_wire_sel <= cs_s_q[1]; // [RL15]
   end

   // Mode bit lives in the register file, so the master switches mode by a normal write
   assign three_wire = mem[GSP_CTRL2_ADDR][GSP_SIM_POS]; // [RL12]
   assign link.dev_sdo_o = tx_q[7];
   assign link.dev_sdo_oe = drive_q && !three_wire; // [RL16]
   assign link.dev_sdi_o = tx_q[7];
   assign link.dev_sdi_oe = drive_q && three_wire; // [RL14]
endmodule : gsp_dev

//--- core/gsp_host.sv
/*
 Host end: an AXI4-Lite slave holding command, data and status registers,
 and a serial master that runs one frame of up to four data bytes per start.
 Assumes the device samples its pins through two flops at the same aclk rate.
*/
// Chosen here: register access over AXI4-Lite and the register addresses.
module gsp_host #(
   parameter int HALF_CYC = gsp_pkg::GSP_HALF_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   gsp_link_if.host link,
   input wire logic [gsp_pkg::GSP_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [gsp_pkg::GSP_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import gsp_pkg::*;

   localparam int CW = $clog2(HALF_CYC + 1);

   gsp_state_t st_q;
   logic [GSP_AW-1:0] awaddr_q;
   logic aw_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_q;
   logic do_wr;
   logic [GSP_CTRL_W-1:0] ctrl_q;
   logic [31:0] txd_q;
   logic [31:0] rxd_q;
   logic done_q;
   logic start_q;
   logic [CW-1:0] cnt_q;
   logic tick;
   logic first_q;
   logic [5:0] idx_q;
   logic [5:0] nidx;
   logic [5:0] last_idx;
   logic [7:0] cmd;
   logic [1:0] rise_p_q;
   logic [1:0] sdo_s_q;
   logic [1:0] sdi_s_q;
   logic sd_in;
   logic [5:0] rd_off;

   // Byte-lane merge for AXI write strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[8*i +: 8] = nw[8*i +: 8];
      return r;
   endfunction : merge

   // Word-aligned match of a bus address against a register offset
   function automatic logic hit(input logic [GSP_AW-1:0] a, input logic [3:0] ofs);
      return {a[GSP_AW-1:2], 2'b00} == ofs;
   endfunction : hit

   // Write channels are taken independently; response once both are held
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready = !w_q && !s_axi_bvalid;
   assign do_wr = aw_q && w_q && !s_axi_bvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= GSP_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (hit(awaddr_q, GSP_OFS_CTRL) || hit(awaddr_q, GSP_OFS_TXD) ||
                            hit(awaddr_q, GSP_OFS_RXD) || hit(awaddr_q, GSP_OFS_STAT)) ?
                           GSP_RESP_OKAY : GSP_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Command and data registers are frozen while a frame runs, so the engine reads them directly
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= GSP_CTRL_RST;
         txd_q <= GSP_TXD_RST;
         start_q <= 1'b0;
      end
      else
      begin
         start_q <= do_wr && hit(awaddr_q, GSP_OFS_CTRL) && wstrb_q[0] && wdata_q[GSP_CTRL_START] &&
                    st_q == GSP_IDLE && !start_q;
         if (do_wr && st_q == GSP_IDLE && !start_q && hit(awaddr_q, GSP_OFS_CTRL))
            ctrl_q <= GSP_CTRL_W'(merge(32'(ctrl_q), wdata_q, wstrb_q)) & ~GSP_CTRL_W'(1);
         if (do_wr && st_q == GSP_IDLE && !start_q && hit(awaddr_q, GSP_OFS_TXD))
            txd_q <= merge(txd_q, wdata_q, wstrb_q);
      end
   end

   // Done is sticky; a finishing frame wins over a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         done_q <= 1'b0;
      else if (st_q == GSP_GAP && tick)
         done_q <= 1'b1;
      else if (do_wr && hit(awaddr_q, GSP_OFS_STAT) && wstrb_q[0] && wdata_q[GSP_STAT_DONE])
         done_q <= 1'b0;
   end

   // Read channel: one read at a time, answered the cycle after it is taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= GSP_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= GSP_RESP_OKAY;
         if (hit(s_axi_araddr, GSP_OFS_CTRL))
            s_axi_rdata <= 32'(ctrl_q);
         else if (hit(s_axi_araddr, GSP_OFS_TXD))
            s_axi_rdata <= txd_q;
         else if (hit(s_axi_araddr, GSP_OFS_RXD))
            s_axi_rdata <= rxd_q;
         else if (hit(s_axi_araddr, GSP_OFS_STAT))
            s_axi_rdata <= {30'h0, done_q, st_q != GSP_IDLE};
         else
         begin
            s_axi_rdata <= '0;
            s_axi_rresp <= GSP_RESP_SLVERR;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Half-period divider for the link clock, held in reset while idle
   assign tick = cnt_q == CW'(HALF_CYC - 1);
   always_ff @(posedge aclk)
   begin
      if (!aresetn || st_q == GSP_IDLE)
         cnt_q <= '0;
      else
         cnt_q <= tick ? '0 : cnt_q + CW'(1);
   end

   // Frame fields and the bit to send next
   assign cmd = {ctrl_q[GSP_CTRL_RW], ctrl_q[GSP_CTRL_INC], ctrl_q[GSP_CTRL_ADDR +: GSP_ADDR_W]}; // [RL6] [RL8] [RL9]
   assign last_idx = 6'(GSP_FRAME_BITS - 1) + {1'b0, ctrl_q[GSP_CTRL_LEN +: 2], 3'b000}; // [RL4]
   assign nidx = first_q ? 6'h00 : idx_q + 6'h01;
   assign rd_off = idx_q - 6'(GSP_CMD_BITS);

   // Frame sequencer: chip select, link clock, data line and its enable
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= GSP_IDLE;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b1;
         link.host_sdi_o <= 1'b1;
         link.host_sdi_oe <= 1'b0;
         first_q <= 1'b0;
         idx_q <= '0;
      end
      else
      begin
         case (st_q)
            GSP_IDLE:
               if (start_q)
               begin
                  st_q <= GSP_LEAD;
                  link.cs_n <= 1'b0; // [RL1]
                  link.host_sdi_oe <= 1'b1;
                  first_q <= 1'b1;
               end
            GSP_LEAD:
               if (tick)
                  st_q <= GSP_RUN;
            GSP_RUN:
               if (tick)
               begin
                  link.sclk <= !link.sclk;
                  if (link.sclk)
                  begin
                     first_q <= 1'b0;
                     idx_q <= nidx;
                     if (nidx < 6'(GSP_CMD_BITS))
                        link.host_sdi_o <= cmd[3'(6'(GSP_CMD_BITS - 1) - nidx)]; // [RL3] [RL9]
                     else
                        link.host_sdi_o <= txd_q[{nidx[4:3] - 2'(1), ~nidx[2:0]}]; // [RL10] [RL11]
                     if (ctrl_q[GSP_CTRL_TRI] && ctrl_q[GSP_CTRL_RW] && nidx == 6'(GSP_CMD_BITS))
                        link.host_sdi_oe <= 1'b0; // [RL14]
                  end
                  else if (idx_q == last_idx)
                     st_q <= GSP_TAIL;
               end
            GSP_TAIL:
               if (tick)
               begin
                  st_q <= GSP_GAP;
                  link.cs_n <= 1'b1; // [RL1] [RL2]
                  link.host_sdi_oe <= 1'b0;
               end
            GSP_GAP:
               if (tick)
                  st_q <= GSP_IDLE;
            default:
               st_q <= GSP_IDLE;
         endcase
      end
   end

   // Data lines cross into aclk; the sample is taken two cycles after the rise to match that delay
   assign sd_in = ctrl_q[GSP_CTRL_TRI] ? sdi_s_q[1] : sdo_s_q[1];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sdo_s_q <= '1;
         sdi_s_q <= '1;
         rise_p_q <= '0;
         rxd_q <= '0;
      end
      else
      begin
         sdo_s_q <= {sdo_s_q[0], link.sdo_line};
         sdi_s_q <= {sdi_s_q[0], link.sdi_line};
         rise_p_q <= {rise_p_q[0], st_q == GSP_RUN && tick && !link.sclk};
         if (rise_p_q[1] && ctrl_q[GSP_CTRL_RW] && idx_q >= 6'(GSP_CMD_BITS))
            rxd_q[{rd_off[4:3], ~rd_off[2:0]}] <= sd_in; // [RL3] [RL10] [RL11]
      end
   end
endmodule : gsp_host

//--- core/gsp_link_if.sv
/*
 Serial link between the host controller and the register port.
 Assumes a pull-up on both data lines: an undriven line reads high.
*/
interface gsp_link_if;
   logic cs_n;
   logic sclk;
   logic host_sdi_o;
   logic host_sdi_oe;
   logic dev_sdi_o;
   logic dev_sdi_oe;
   logic dev_sdo_o;
   logic dev_sdo_oe;
   logic sdi_line;
   logic sdo_line;

   // Resolve the shared lines; a released line floats high through the pull-up
   assign sdi_line = host_sdi_oe ? host_sdi_o : (dev_sdi_oe ? dev_sdi_o : 1'b1);
   assign sdo_line = dev_sdo_oe ? dev_sdo_o : 1'b1;

   modport host (output cs_n, output sclk, output host_sdi_o, output host_sdi_oe,
                 input sdi_line, input sdo_line);
   modport dev (input cs_n, input sclk, input sdi_line,
                output dev_sdi_o, output dev_sdi_oe, output dev_sdo_o, output dev_sdo_oe);
endinterface : gsp_link_if

//--- core/gsp_pkg.sv
/*
 Shared constants and types for the gyro serial register port: frame layout,
 device register space, host register map and link timing.
 Assumes a single 40 MHz system clock on both ends.
*/
package gsp_pkg;
   // System clock and link clock timing
   localparam int GSP_CLK_NS = 25;
   localparam int GSP_SCK_NS = 200;
   localparam int GSP_HALF_CYC = (GSP_SCK_NS + 2 * GSP_CLK_NS - 1) / (2 * GSP_CLK_NS);
   localparam int GSP_SYNC_STAGES = 2;

   // Frame layout: command byte then data bytes, MSB first
   localparam int GSP_CMD_BITS = 8;
   localparam int GSP_BYTE_BITS = 8;
   localparam int GSP_FRAME_BITS = 16;
   localparam int GSP_RW_POS = 7;
   localparam int GSP_INC_POS = 6;
   localparam int GSP_ADDR_W = 6;
   localparam int GSP_NREGS = 64;
   localparam int GSP_MAX_BYTES = 4;

   // Device register space
   localparam logic [5:0] GSP_CTRL2_ADDR = 6'h01;
   localparam int GSP_SIM_POS = 0;
   localparam logic [7:0] GSP_REG_RST = 8'h00;

   // Host register map over AXI4-Lite
   localparam int GSP_AW = 4;
   localparam logic [3:0] GSP_OFS_CTRL = 4'h0;
   localparam logic [3:0] GSP_OFS_TXD = 4'h4;
   localparam logic [3:0] GSP_OFS_RXD = 4'h8;
   localparam logic [3:0] GSP_OFS_STAT = 4'hc;
   localparam int GSP_CTRL_START = 0;
   localparam int GSP_CTRL_RW = 1;
   localparam int GSP_CTRL_INC = 2;
   localparam int GSP_CTRL_TRI = 3;
   localparam int GSP_CTRL_LEN = 4;
   localparam int GSP_CTRL_ADDR = 8;
   localparam int GSP_CTRL_W = 14;
   localparam logic [13:0] GSP_CTRL_RST = 14'h0000;
   localparam logic [31:0] GSP_TXD_RST = 32'h0000_0000;
   localparam int GSP_STAT_BUSY = 0;
   localparam int GSP_STAT_DONE = 1;
   localparam logic [1:0] GSP_RESP_OKAY = 2'h0;
   localparam logic [1:0] GSP_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {GSP_IDLE, GSP_LEAD, GSP_RUN, GSP_TAIL, GSP_GAP} gsp_state_t;
endpackage : gsp_pkg
